// ---- core/capture_compare_mode_select.sv ----
// Capture/compare/PWM channel with mode selection and a plain register port
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ccp_defs.svh"

// Summary of operation
// (R1) Select bit 1 gives input capture; 0 gives compare, PWM or timer by mode.
// (R2) Capture modes 0001, 0010, 0011: rising, falling, both edges.
// (R3) Capture mode 0000 is edge detect, capturing both edges.
// (R4) Capture modes 0100 and 0101: every 4th and 16th rising edge.
// (R5) Capture codes 1xxx and 011x are reserved and capture nothing.
// (R6) Compare mode 0000 is a plain timer with outputs disabled.
// (R7) Compare modes 0001, 0010, 0011: match drives high, low, or toggles.
// (R8) Mode 0100 dual edge compare unbuffered; 0101 buffered.
// (R9) Mode 0110 makes center-aligned pulses from buffered compare values.
// (R10) Mode 0111 makes a variable frequency pulse.
// (R11) Mode 1111 stops the pulse generator; timer runs from the selected input.
// (R12) Compare codes 1110, 110x, 10xx are reserved with no output behaviour.
// (R13) Software never programs reserved codes; their behaviour is not relied upon.
module capture_compare_mode_select (
	input wire logic I_CORE_CLK,
	input wire logic I_RST_B,
	input wire logic [3:0] I_ADDR,
	input wire logic [15:0] I_WR_DATA,
	input wire logic I_WR_STB,
	input wire logic I_RD_STB,
	input wire logic I_CAP_IN,
	input wire logic [7:0] I_EXT_SRC,
	output logic [15:0] O_RD_DATA,
	output logic O_CMP_OUT,
	output logic O_CMP_OE
);
	// ==========================================
	// Decode helpers
	function automatic logic cap_reserved(input logic [3:0] m);
		cap_reserved = m[3] || (m[3:1] == 3'b011);
	endfunction

	function automatic logic cmp_reserved(input logic [3:0] m);
		cmp_reserved = m[3] && (m != `CCP_M_EXT);
	endfunction

	ccp_pkg::bus_req_t req;
	ccp_pkg::ctrl_t ctrl_r;
	ccp_pkg::dir_t dir_r;
	ccp_pkg::dir_t dir_nxt;
	logic [15:0] period_r;
	logic [15:0] cmpa_r;
	logic [15:0] cmpb_r;
	logic [15:0] bufa_r;
	logic [15:0] bufb_r;
	logic [15:0] timer_r;
	logic [15:0] timer_nxt;
	logic [15:0] capture_r;
	logic [15:0] acc_r;
	logic [16:0] acc_sum;
	logic capflag_r;
	logic out_nxt;
	logic oe_nxt;
	logic [15:0] rd_nxt;
	logic cap_s1_r;
	logic cap_s2_r;
	logic [7:0] ext_s1_r;
	logic [7:0] ext_s2_r;
	logic ext_prev_r;
	logic cap_fire;

	// ==========================================
	// Bus decode
	logic [3:0] mode;
	logic sel;
	logic wr_ctrl;
	logic wr_period;
	logic wr_cmpa;
	logic wr_cmpb;
	logic wr_timer;
	logic wr_status;

	assign req = '{addr: I_ADDR, wdata: I_WR_DATA, wr: I_WR_STB, rd: I_RD_STB};
	assign mode = ctrl_r.channel_mode_field;
	assign sel = ctrl_r.capture_compare_select;
	assign wr_ctrl = req.wr && req.addr == `CCP_ADR_CTRL;
	assign wr_period = req.wr && req.addr == `CCP_ADR_PERIOD;
	assign wr_cmpa = req.wr && req.addr == `CCP_ADR_CMPA;
	assign wr_cmpb = req.wr && req.addr == `CCP_ADR_CMPB;
	assign wr_timer = req.wr && req.addr == `CCP_ADR_TIMER;
	assign wr_status = req.wr && req.addr == `CCP_ADR_STATUS;

	// ==========================================
	// Pin synchronisers; first stages feed only second stages
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			cap_s1_r <= 1'b0;
			cap_s2_r <= 1'b0;
			ext_s1_r <= 8'h00;
			ext_s2_r <= 8'h00;
		end else begin
			cap_s1_r <= I_CAP_IN;
			cap_s2_r <= cap_s1_r;
			ext_s1_r <= I_EXT_SRC;
			ext_s2_r <= ext_s1_r;
		end
	end

	// ==========================================
	// Timer clocking and mode decode
	logic cmp_mode;
	logic ext_mode;
	logic ext_lvl;
	logic ext_rise;
	logic tick;
	logic center;
	logic buffered;
	logic at_period;
	logic cyc_end;
	logic [15:0] eff_a;
	logic [15:0] eff_b;
	logic match_a;
	logic match_b;

	assign cmp_mode = !sel; // R1
	assign ext_mode = cmp_mode && mode == `CCP_M_EXT; // R11
	assign ext_lvl = ext_s2_r[ctrl_r.input_clock_source_select];
	assign ext_rise = ext_lvl & ~ext_prev_r;
	assign tick = ext_mode ? ext_rise : 1'b1; // R11
	assign center = cmp_mode && mode == `CCP_M_6;
	assign buffered = cmp_mode && (mode == `CCP_M_5 || center); // R8 R9
	assign at_period = timer_r == period_r;
	// Buffered values change only at a cycle boundary, so a mid-cycle write cannot glitch the pulse
	assign cyc_end = tick && (center ? (dir_r == ccp_pkg::DIR_DOWN && timer_r == 16'h0000) : at_period);
	assign eff_a = buffered ? bufa_r : cmpa_r; // R8
	assign eff_b = buffered ? bufb_r : cmpb_r; // R8
	assign match_a = tick && timer_r == eff_a;
	assign match_b = tick && timer_r == eff_b;

	// Up/down count for center-aligned pulses, wrap at period otherwise
	always_comb begin
		dir_nxt = dir_r;
		timer_nxt = timer_r;
		if (wr_timer) begin
			timer_nxt = req.wdata;
		end else if (tick && center) begin // R9
			if (dir_r == ccp_pkg::DIR_UP) begin
				dir_nxt = at_period ? ccp_pkg::DIR_DOWN : ccp_pkg::DIR_UP;
				timer_nxt = at_period ? 16'(timer_r - 16'h0001) : 16'(timer_r + 16'h0001);
			end else begin
				dir_nxt = (timer_r == 16'h0000) ? ccp_pkg::DIR_UP : ccp_pkg::DIR_DOWN;
				timer_nxt = (timer_r == 16'h0000) ? 16'h0001 : 16'(timer_r - 16'h0001);
			end
		end else if (tick) begin // R6 R11
			dir_nxt = ccp_pkg::DIR_UP;
			timer_nxt = at_period ? 16'h0000 : 16'(timer_r + 16'h0001);
		end
	end

	// ==========================================
	// Output generator
	assign acc_sum = {1'b0, acc_r} + {1'b0, cmpa_r};

	always_comb begin
		out_nxt = 1'b0;
		oe_nxt = 1'b0;
		if (cmp_mode && !cmp_reserved(mode) && mode != `CCP_M_0 && mode != `CCP_M_EXT) begin // R6 R11 R12
			oe_nxt = 1'b1;
			case (mode)
				`CCP_M_1: out_nxt = match_a ? 1'b1 : O_CMP_OUT; // R7
				`CCP_M_2: out_nxt = match_a ? 1'b0 : O_CMP_OUT; // R7
				`CCP_M_3: out_nxt = match_a ? ~O_CMP_OUT : O_CMP_OUT; // R7
				`CCP_M_4, `CCP_M_5: out_nxt = match_b ? 1'b0 : (match_a ? 1'b1 : O_CMP_OUT); // R8
				`CCP_M_6: begin
					if (dir_r == ccp_pkg::DIR_UP && match_a) begin // R9
						out_nxt = 1'b1;
					end else if (dir_r == ccp_pkg::DIR_DOWN && match_b) begin
						out_nxt = 1'b0;
					end else begin
						out_nxt = O_CMP_OUT;
					end
				end
				`CCP_M_7: out_nxt = acc_sum[16]; // R10
				default: out_nxt = 1'b0;
			endcase
		end
	end

	// ==========================================
	// Capture qualification
	capture_edge_qualifier u_edge (
		.i_clk(I_CORE_CLK),
		.i_rst_b(I_RST_B),
		.i_enable(sel && !cap_reserved(mode)), // R1 R5
		.i_level(cap_s2_r),
		.i_mode(mode),
		.o_fire(cap_fire)
	);

	// ==========================================
	// Read data selection; unmapped offsets read zero
	assign rd_nxt = !req.rd ? 16'h0000 :
		(req.addr == `CCP_ADR_CTRL) ? {5'h00, ctrl_r.input_clock_source_select, 3'h0,
			sel, mode} :
		(req.addr == `CCP_ADR_PERIOD) ? period_r :
		(req.addr == `CCP_ADR_CMPA) ? cmpa_r :
		(req.addr == `CCP_ADR_CMPB) ? cmpb_r :
		(req.addr == `CCP_ADR_TIMER) ? timer_r :
		(req.addr == `CCP_ADR_CAPTURE) ? capture_r :
		(req.addr == `CCP_ADR_STATUS) ? {14'h0000, O_CMP_OUT, capflag_r} : 16'h0000;

	// ==========================================
	// Software registers
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			ctrl_r <= `CCP_CTRL_RST;
			period_r <= `CCP_PERIOD_RST;
			cmpa_r <= `CCP_WORD_RST;
			cmpb_r <= `CCP_WORD_RST;
			O_RD_DATA <= 16'h0000;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= {req.wdata[`CCP_SRC_LSB+2:`CCP_SRC_LSB], req.wdata[`CCP_SEL_BIT:`CCP_MODE_LSB]};
			end
			if (wr_period) begin
				period_r <= req.wdata;
			end
			if (wr_cmpa) begin
				cmpa_r <= req.wdata;
			end
			if (wr_cmpb) begin
				cmpb_r <= req.wdata;
			end
			O_RD_DATA <= rd_nxt;
		end
	end

	// Channel state; capture flag set wins over a write-one clear
	always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			timer_r <= `CCP_WORD_RST;
			dir_r <= ccp_pkg::DIR_UP;
			bufa_r <= `CCP_WORD_RST;
			bufb_r <= `CCP_WORD_RST;
			acc_r <= `CCP_WORD_RST;
			capture_r <= `CCP_WORD_RST;
			capflag_r <= 1'b0;
			ext_prev_r <= 1'b0;
			O_CMP_OUT <= 1'b0;
			O_CMP_OE <= 1'b0;
		end else begin
			timer_r <= timer_nxt;
			dir_r <= dir_nxt;
			ext_prev_r <= ext_lvl;
			if (!buffered || cyc_end) begin // R8 R9
				bufa_r <= cmpa_r;
				bufb_r <= cmpb_r;
			end
			acc_r <= (cmp_mode && mode == `CCP_M_7) ? acc_sum[15:0] : 16'h0000; // R10
			if (cap_fire) begin // R2
				capture_r <= timer_r;
			end
			capflag_r <= cap_fire | (capflag_r & ~(wr_status & req.wdata[`CCP_ST_CAPFLAG]));
			O_CMP_OUT <= out_nxt;
			O_CMP_OE <= oe_nxt;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_B);

	a_capture_loads_timer: assert property (cap_fire |=> capture_r == $past(timer_r) && capflag_r) // R2
		else $error("capture did not load timer value");
	a_sel_no_drive: assert property (sel |=> !O_CMP_OE) // R1
		else $error("output enabled in capture operation");
	a_cap_reserved_idle: assert property (sel && cap_reserved(mode) ##1 sel && cap_reserved(mode) |-> !cap_fire) // R5
		else $error("reserved capture code captured");
	a_edge_detect_both: assert property (sel && mode == `CCP_M_0 && $changed(cap_s2_r) ##1 $stable(ctrl_r)
		|-> cap_fire) else $error("edge detect missed an edge"); // R3
	a_timer_only_quiet: assert property (cmp_mode && mode == `CCP_M_0 |=> !O_CMP_OUT && !O_CMP_OE) // R6
		else $error("timer mode drove output");
	a_single_high: assert property (cmp_mode && mode == `CCP_M_1 && match_a |=> O_CMP_OUT) // R7
		else $error("match did not drive high");
	a_single_low: assert property (cmp_mode && mode == `CCP_M_2 && match_a |=> !O_CMP_OUT) // R7
		else $error("match did not drive low");
	a_single_toggle: assert property (cmp_mode && mode == `CCP_M_3 && match_a |=> O_CMP_OUT != $past(O_CMP_OUT)) // R7
		else $error("match did not toggle");
	a_dual_clear: assert property (cmp_mode && (mode == `CCP_M_4 || mode == `CCP_M_5) && match_b
		|=> !O_CMP_OUT) else $error("second edge missed"); // R8
	a_buffer_hold: assert property (buffered && !cyc_end |=> $stable(bufa_r) && $stable(bufb_r)) // R8
		else $error("buffered value changed mid cycle");
	a_center_rise: assert property (center && dir_r == ccp_pkg::DIR_UP && match_a |=> O_CMP_OUT) // R9
		else $error("center pulse did not start");
	a_vfp_carry: assert property (cmp_mode && mode == `CCP_M_7 |=> O_CMP_OUT == $past(acc_sum[16])) // R10
		else $error("pulse does not follow carry");
	a_ext_hold: assert property (ext_mode && !ext_rise && !wr_timer |=> $stable(timer_r) && !O_CMP_OE) // R11
		else $error("external mode counted without input edge");
	a_cmp_reserved_low: assert property (cmp_mode && cmp_reserved(mode) |=> !O_CMP_OUT && !O_CMP_OE) // R12
		else $error("reserved compare code drove output");

	c_capture: cover property (cap_fire ##1 capflag_r);
	c_toggle: cover property (cmp_mode && mode == `CCP_M_3 && match_a);
	c_center_turn: cover property (center && dir_r == ccp_pkg::DIR_UP ##1 dir_r == ccp_pkg::DIR_DOWN);
	c_ext_count: cover property (ext_mode && ext_rise);
endmodule

// ---- core/capture_edge_qualifier.sv ----
// Edge selection and prescaling for capture operation
`timescale 1ns/1ps
`include "ccp_defs.svh"

module capture_edge_qualifier (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_enable,
	input wire logic i_level,
	input wire logic [3:0] i_mode,
	output logic o_fire
);
	logic prev_r;
	logic [3:0] div_r;
	logic [3:0] div_nxt;
	logic rise;
	logic fall;
	logic prescaled;
	logic div_last;
	logic fire_nxt;

	// ==========================================
	// Edge detection and qualification
	assign rise = i_level & ~prev_r;
	assign fall = ~i_level & prev_r;
	assign prescaled = (i_mode == `CCP_M_4) || (i_mode == `CCP_M_5);
	assign div_last = (i_mode == `CCP_M_4) ? (div_r == `CCP_DIV4_LAST) : (div_r == `CCP_DIV16_LAST);
	// Counter cleared outside prescaled modes so a prescaled mode entered from a non-prescaled one starts a fresh count
	assign div_nxt = !(i_enable && prescaled) ? 4'h0 :
		!rise ? div_r :
		div_last ? 4'h0 : 4'(div_r + 4'h1);
	assign fire_nxt = !i_enable ? 1'b0 : // R5
		(i_mode == `CCP_M_0 || i_mode == `CCP_M_3) ? (rise | fall) : // R2 R3
		(i_mode == `CCP_M_1) ? rise : // R2
		(i_mode == `CCP_M_2) ? fall : // R2
		prescaled ? (rise & div_last) : 1'b0; // R4

	// ==========================================
	// State
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_r <= 1'b0;
			div_r <= 4'h0;
			o_fire <= 1'b0;
		end else begin
			prev_r <= i_level;
			div_r <= div_nxt;
			o_fire <= fire_nxt;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_div4_only_last: assert property (i_enable && i_mode == `CCP_M_4 && rise && div_r != `CCP_DIV4_LAST
		|=> !o_fire) else $error("capture fired before fourth edge"); // R4
	a_fall_only: assert property (i_enable && i_mode == `CCP_M_2 && fall |=> o_fire)
		else $error("falling edge not captured"); // R2
	c_div16_fire: cover property (i_enable && i_mode == `CCP_M_5 ##1 o_fire);
endmodule

// ---- core/ccp_defs.svh ----
// Offsets, field positions, reset values and mode codes of the capture/compare channel
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

// ==========================================
// Register offsets (word index on the plain port)
`define CCP_ADR_CTRL 4'h0
`define CCP_ADR_PERIOD 4'h1
`define CCP_ADR_CMPA 4'h2
`define CCP_ADR_CMPB 4'h3
`define CCP_ADR_TIMER 4'h4
`define CCP_ADR_CAPTURE 4'h5
`define CCP_ADR_STATUS 4'h6

// ==========================================
// Control field positions
`define CCP_MODE_LSB 0
`define CCP_SEL_BIT 4
`define CCP_SRC_LSB 8

// Status bit positions
`define CCP_ST_CAPFLAG 0
`define CCP_ST_OUTLVL 1

// ==========================================
// Reset values
`define CCP_CTRL_RST 8'h00
`define CCP_PERIOD_RST 16'hFFFF
`define CCP_WORD_RST 16'h0000

// ==========================================
// Mode codes
`define CCP_M_0 4'h0
`define CCP_M_1 4'h1
`define CCP_M_2 4'h2
`define CCP_M_3 4'h3
`define CCP_M_4 4'h4
`define CCP_M_5 4'h5
`define CCP_M_6 4'h6
`define CCP_M_7 4'h7
`define CCP_M_EXT 4'hF

// Prescaler terminal counts for every 4th and 16th edge
`define CCP_DIV4_LAST 4'h3
`define CCP_DIV16_LAST 4'hF

`endif

// ---- core/ccp_pkg.sv ----
// Types shared by the capture/compare channel files
package ccp_pkg;
	// Channel control word as held in the control register
	typedef struct packed {
		logic [2:0] input_clock_source_select;
		logic capture_compare_select;
		logic [3:0] channel_mode_field;
	} ctrl_t;

	// One register access from the plain port
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	// Count direction of the center-aligned timer
	typedef enum logic {
		DIR_UP = 1'b0,
		DIR_DOWN = 1'b1
	} dir_t;
endpackage

// ---- tb/capture_compare_mode_select_tb.sv ----
// Self-checking bench for the capture/compare channel
`timescale 1ns/1ps
`include "ccp_defs.svh"

// ==========
// Bench top
module capture_compare_mode_select_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cap;
	logic [7:0] ext;
	logic [15:0] rdata;
	logic cmp_out;
	logic cmp_oe;
	logic [15:0] v;
	int errors = 0;
	int cmp_count = 0;
	int hi;
	int ch;
	int oe;

	// 25 MHz core clock
	always #20 clk = ~clk;

	capture_compare_mode_select uut (
		.I_CORE_CLK(clk),
		.I_RST_B(rst_b),
		.I_ADDR(addr),
		.I_WR_DATA(wdata),
		.I_WR_STB(wr),
		.I_RD_STB(rd),
		.I_CAP_IN(cap),
		.I_EXT_SRC(ext),
		.O_RD_DATA(rdata),
		.O_CMP_OUT(cmp_out),
		.O_CMP_OE(cmp_oe)
	);

	ccp_pin_model pins (
		.i_clk(clk),
		.o_cap(cap),
		.o_ext(ext)
	);

	// ==========
	// Shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Counts high cycles, level changes and enabled cycles of the output
	task automatic measure(input int n);
		logic prev;
		hi = 0;
		ch = 0;
		oe = 0;
		@(posedge clk);
		#1;
		prev = cmp_out;
		repeat (n) begin
			@(posedge clk);
			#1;
			hi += int'(cmp_out === 1'b1);
			ch += int'(cmp_out !== prev);
			oe += int'(cmp_oe === 1'b1);
			prev = cmp_out;
		end
	endtask

	// Flag check after the sync latency, then a clear by writing one
	task automatic cap_check(input logic e);
		repeat (8) @(posedge clk);
		rd_reg(`CCP_ADR_STATUS, v);
		chk(v & 16'h0001, {15'h0000, e});
		wr_reg(`CCP_ADR_STATUS, 16'h0001);
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==========
	// Test sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_reg(`CCP_ADR_CTRL, v);
		chk(v, 16'h0000);
		rd_reg(`CCP_ADR_PERIOD, v);
		chk(v, 16'hFFFF);
		rd_reg(`CCP_ADR_CMPB, v);
		chk(v, 16'h0000);
		rd_reg(4'h9, v);
		chk(v, 16'h0000);
		measure(20);
		chk(16'(hi + oe), 16'h0000);
		$display("reset and timer mode done");
		// Single edge modes, period of ten cycles
		wr_reg(`CCP_ADR_PERIOD, 16'h0009);
		wr_reg(`CCP_ADR_CMPA, 16'h0003);
		wr_reg(`CCP_ADR_TIMER, 16'h0000);
		wr_reg(`CCP_ADR_CTRL, 16'h0001);
		measure(30);
		measure(10);
		chk(16'(hi), 16'h000A);
		chk(16'(oe), 16'h000A);
		wr_reg(`CCP_ADR_CTRL, 16'h0002);
		measure(30);
		measure(10);
		chk(16'(hi), 16'h0000);
		wr_reg(`CCP_ADR_CTRL, 16'h0003);
		measure(100);
		chk(16'(ch), 16'h000A);
		$display("single edge done");
		// Dual edge: set after 2, clear after 6, four high cycles a period
		wr_reg(`CCP_ADR_CMPA, 16'h0002);
		wr_reg(`CCP_ADR_CMPB, 16'h0006);
		for (int m = 4; m < 6; m++) begin
			wr_reg(`CCP_ADR_CTRL, 16'(m));
			measure(30);
			measure(100);
			chk(16'(hi), 16'h0028);
		end
		wr_reg(`CCP_ADR_CTRL, 16'h0006);
		measure(40);
		measure(100);
		chk(16'(hi > 0 && hi < 100), 16'h0001);
		chk(16'(oe), 16'h0064);
		// Quarter step accumulator carries every fourth cycle
		wr_reg(`CCP_ADR_CMPA, 16'h4000);
		wr_reg(`CCP_ADR_CTRL, 16'h0007);
		measure(100);
		chk(16'(hi), 16'h0019);
		chk(16'(ch), 16'h0032);
		$display("pulse modes done");
		// External input: only source 2 may step the timer
		wr_reg(`CCP_ADR_CTRL, 16'h020F);
		wr_reg(`CCP_ADR_TIMER, 16'h0000);
		pins.ext_pulses(1, 3);
		pins.ext_pulses(2, 5);
		repeat (6) @(posedge clk);
		rd_reg(`CCP_ADR_TIMER, v);
		chk(v, 16'h0005);
		measure(20);
		chk(16'(hi + oe), 16'h0000);
		$display("external input done");
		// Compare selected: the pin must not capture
		wr_reg(`CCP_ADR_CTRL, 16'h0001);
		wr_reg(`CCP_ADR_STATUS, 16'h0001);
		pins.cap_pulses(1);
		cap_check(1'b0);
		// Captured value: timer cleared, pin rises one edge later, timer taken four edges after that
		wr_reg(`CCP_ADR_PERIOD, 16'hFFFF);
		wr_reg(`CCP_ADR_CTRL, 16'h0011);
		wr_reg(`CCP_ADR_TIMER, 16'h0000);
		pins.cap_level(1'b1);
		rd_reg(`CCP_ADR_CAPTURE, v);
		chk(v, 16'h0004);
		// Rising-only mode ignores the fall, and the capture word is read only
		pins.cap_level(1'b0);
		wr_reg(`CCP_ADR_CAPTURE, 16'h1234);
		rd_reg(`CCP_ADR_CAPTURE, v);
		chk(v, 16'h0004);
		// Edge modes, defined codes only
		for (int m = 0; m < 4; m++) begin
			wr_reg(`CCP_ADR_CTRL, 16'h0010 | 16'(m));
			wr_reg(`CCP_ADR_STATUS, 16'h0001);
			pins.cap_level(1'b1);
			cap_check(m != 2);
			pins.cap_level(1'b0);
			cap_check(m != 1);
		end
		// Prescaled: one edge short, then the terminal edge
		for (int m = 4; m < 6; m++) begin
			wr_reg(`CCP_ADR_CTRL, 16'h0010 | 16'(m));
			wr_reg(`CCP_ADR_STATUS, 16'h0001);
			pins.cap_pulses(m == 4 ? 3 : 15);
			cap_check(1'b0);
			pins.cap_pulses(1);
			cap_check(1'b1);
		end
		$display("capture done");
		conclude();
	end

	// Whole run is well under 10000 cycles
	initial begin
		#(40 * 30000);
		errors++;
		conclude();
	end
endmodule

// ---- tb/ccp_pin_model.sv ----
// Behavioural model of the channel's capture and clock-source pins
`timescale 1ns/1ps

// ==========
// Pin model
module ccp_pin_model (
	input wire logic i_clk,
	output logic o_cap,
	output logic [7:0] o_ext
);
	// Pins idle low until a test moves them
	initial begin
		o_cap = 1'b0;
		o_ext = 8'h00;
	end

	// Held three cycles so the 2-flop synchroniser cannot miss it
	task automatic cap_level(input logic v);
		@(posedge i_clk);
		o_cap <= v;
		repeat (3) @(posedge i_clk);
	endtask

	// Whole pulses: one rising and one falling edge each
	task automatic cap_pulses(input int n);
		for (int k = 0; k < n; k++) begin
			cap_level(1'b1);
			cap_level(1'b0);
		end
	endtask

	// Slow rising edges on one external source
	task automatic ext_pulses(input int idx, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge i_clk);
			o_ext[idx] <= 1'b1;
			repeat (3) @(posedge i_clk);
			o_ext[idx] <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
	endtask
endmodule
